/* dram_device_end.sv */
// DRAM device end: bank rows, precharge timing and read bursts
`timescale 1ns/100ps
module dram_device_end
  import dram_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  dram_link_if.device link,
  input wire logic [1:0] burst_mode,
  input wire logic [3:0] additive_latency,
  input wire logic [3:0] cas_latency,
  output logic [NBANK-1:0] bank_open,
  output logic protocol_error,
  output logic read_busy
);

  typedef struct packed {
    logic v;
    logic [3:0] beats;
    logic [DQ_W-1:0] seed;
  } slot_t;

  typedef struct packed {
    logic [2:0] ck_s;
    cmd_pins_t cmd_s1;
    cmd_pins_t cmd_s2;
    logic [NBANK-1:0] open;
    logic [NBANK-1:0][ROW_W-1:0] row;
    logic [NBANK-1:0][CNT_W-1:0] rp;
    logic [NBANK-1:0][CNT_W-1:0] ap;
    logic [CNT_W-1:0] ccd;
    slot_t [PIPE_D-1:0] pipe;
    logic busy;
    logic [3:0] beat;
    logic [3:0] len;
    logic [2:0] ph;
    logic [DQ_W-1:0] seed;
    logic [DQ_W-1:0] dq;
    logic dqs;
    logic err;
  } dev_state_t;

  dev_state_t q;
  dev_state_t d;

  logic rise;
  cmd_t cmd;
  logic [BA_W-1:0] ba;
  logic [ROW_W-1:0] addr;
  logic [CNT_W-1:0] rl;
  logic [COL_W-1:0] col;

  // Beats of one burst from mode field and chop bit
  function automatic logic [3:0] burst_beats(input logic [1:0] mode, input logic chop);
    logic [3:0] n;
    n = BEATS_BL8;
    if (mode == BURST_FIX4) begin
      n = BEATS_BC4; // RQ15
    end else if (mode == BURST_OTF) begin
      n = chop ? BEATS_BL8 : BEATS_BC4; // RQ10 RQ14
    end
    return n;
  endfunction

  ////////////////////////////////////////////////////////////////////////////

  assign rise = q.ck_s[1] & ~q.ck_s[2];
  assign cmd = decode(q.cmd_s2);
  assign ba = q.cmd_s2.ba;
  assign addr = q.cmd_s2.addr;
  assign rl = CNT_W'(additive_latency) + CNT_W'(cas_latency); // RQ20
  // Column takes low bits only; the chop bit never reaches it
  assign col = addr[COL_W-1:0]; // RQ12

  always_comb begin
    d = q;
    d.ck_s = {q.ck_s[1:0], link.ck};
    d.cmd_s1 = link.cmd;
    d.cmd_s2 = q.cmd_s1;
    d.err = 1'b0;

    // Burst beats on every half link period
    if (q.busy) begin
      if (q.ph == PH_LAST) begin
        d.ph = '0;
        if (q.beat == q.len) begin
          d.busy = 1'b0;
          d.dqs = 1'b0;
        end else begin
          d.dq = q.seed + DQ_W'(q.beat); // RQ21
          d.dqs = ~q.dqs; // RQ21
          d.beat = q.beat + 4'h1;
        end
      end else begin
        d.ph = q.ph + 3'h1;
      end
    end

    if (rise) begin
      for (int i = 0; i < PIPE_D - 1; i++) begin
        d.pipe[i] = q.pipe[i + 1];
      end
      d.pipe[PIPE_D-1] = '0;

      // A burst due now overrides the end of the previous one
      if (q.pipe[0].v) begin
        d.busy = 1'b1; // RQ20
        d.beat = 4'h1;
        d.len = q.pipe[0].beats;
        d.seed = q.pipe[0].seed;
        d.dq = q.pipe[0].seed;
        d.dqs = 1'b1; // RQ21
        d.ph = '0;
      end

      if (q.ccd != '0) begin
        d.ccd = q.ccd - 5'h01;
      end

      for (int b = 0; b < NBANK; b++) begin
        if (q.rp[b] != '0) begin
          d.rp[b] = q.rp[b] - 5'h01;
        end
        if (q.ap[b] == 5'h01) begin
          d.ap[b] = '0;
          d.open[b] = 1'b0; // RQ6
          d.rp[b] = T_RP_CK - 5'h01; // RQ9
        end else if (q.ap[b] != '0) begin
          d.ap[b] = q.ap[b] - 5'h01;
        end
      end

      unique case (cmd)
        CMD_ACT: begin
          if (q.open[ba] || q.rp[ba] != '0) begin
            d.err = 1'b1; // RQ3 RQ5
          end else begin
            d.open[ba] = 1'b1; // RQ1
            d.row[ba] = addr; // RQ1
          end
        end
        CMD_PRE: begin
          for (int b = 0; b < NBANK; b++) begin
            if (addr[AP_BIT] || BA_W'(b) == ba) begin // RQ4
              // Idle or precharging banks restart the period too
              d.open[b] = 1'b0; // RQ8
              d.rp[b] = T_RP_CK - 5'h01; // RQ9
              d.ap[b] = '0;
            end
          end
        end
        CMD_READ: begin
          if (!q.open[ba] || q.ccd != '0) begin
            d.err = 1'b1; // RQ7 RQ11
          end else begin
            d.ccd = T_CCD_CK - 5'h01; // RQ11
            d.pipe[(rl == '0) ? '0 : rl - 5'h01] = '{
              v: 1'b1,
              beats: burst_beats(burst_mode, addr[BC_BIT]),
              seed: q.row[ba][DQ_W-1:0] ^ col[DQ_W-1:0]
            };
            if (addr[AP_BIT]) begin
              d.ap[ba] = CNT_W'(additive_latency) + T_RTP_CK; // RQ13 RQ16
            end
          end
        end
        CMD_NOP: begin
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  // Rows stay open until a precharge or auto precharge clears them
  assign bank_open = q.open; // RQ2
  assign protocol_error = q.err;
  assign read_busy = q.busy;
  assign link.dev_dq_o = q.dq;
  assign link.dev_dq_oe = q.busy;
  assign link.dev_dqs_o = q.dqs;
  assign link.dev_dqs_oe = q.busy;

endmodule

/* dram_pkg.sv */
// Shared constants, types and command coding for the DRAM bank and read link
// Overview of operation
// RQ1: Activate opens row selected by bank, row.
// RQ2: Open row stays open until bank precharged.
// RQ3: Controller precharges before activating another row.
// RQ4: Precharge closes one bank or all banks.
// RQ5: Activation only after row precharge period.
// RQ6: Other-bank reads allowed during auto precharge.
// RQ7: Controller activates before reading an idle bank.
// RQ8: Precharge of idle bank is no error.
// RQ9: Precharge period timed from latest precharge.
// RQ10: Chop bit low four beats, high eight.
// RQ11: Column commands spaced four clocks, chopped too.
// RQ12: Chop bit is not a column address bit.
// RQ13: Auto precharge chosen per command, independently.
// RQ14: Burst field 00 fixed eight, 01 per command.
// RQ15: Burst field 10 always four beats.
// RQ16: Precharge after read waits additive plus delay.
// RQ17: Read-to-precharge delay max(4 clocks, 7.5 ns).
// RQ18: Precharge also waits activate-to-precharge minimum.
// RQ19: Reactivate after precharge period and cycle time.
// RQ20: First beat after additive plus CAS latency.
// RQ21: Two beats per clock, strobe toggles with data.
package dram_pkg;

  localparam int NBANK = 8;
  localparam int BA_W = 3;
  localparam int ROW_W = 16;
  localparam int COL_W = 10;
  localparam int DQ_W = 8;
  localparam int CNT_W = 5;
  localparam int PIPE_D = 32;
  localparam int AP_BIT = 10;
  localparam int BC_BIT = 12;

  // Link clock made by the controller from pclk
  localparam int CLK_NS = 40;
  localparam int LINK_PERIOD_NS = 320;
  localparam int CK_HALF = LINK_PERIOD_NS / CLK_NS / 2;
  localparam logic [2:0] PH_LAST = 3'(CK_HALF - 1);

  // Bank timing in link clocks
  localparam logic [CNT_W-1:0] T_RP_CK = 5'h05;
  localparam logic [CNT_W-1:0] T_RAS_CK = 5'h08;
  localparam logic [CNT_W-1:0] T_RC_CK = 5'h0D;
  localparam logic [CNT_W-1:0] T_CCD_CK = 5'h04;
  localparam int RTP_MIN_NCK = 4;
  localparam real RTP_MIN_NS = 7.5;
  localparam int RTP_NS_CK = int'($ceil(RTP_MIN_NS / LINK_PERIOD_NS));
  localparam logic [CNT_W-1:0] T_RTP_CK =
    CNT_W'(RTP_NS_CK > RTP_MIN_NCK ? RTP_NS_CK : RTP_MIN_NCK);

  // Burst field of mode register zero
  localparam logic [1:0] BURST_FIX8 = 2'h0;
  localparam logic [1:0] BURST_OTF = 2'h1;
  localparam logic [1:0] BURST_FIX4 = 2'h2;
  localparam logic [3:0] BEATS_BL8 = 4'h8;
  localparam logic [3:0] BEATS_BC4 = 4'h4;

  // Pin coding of ras_n, cas_n, we_n
  localparam logic [2:0] PIN_ACT = 3'h3;
  localparam logic [2:0] PIN_PRE = 3'h2;
  localparam logic [2:0] PIN_READ = 3'h5;
  localparam logic [2:0] PIN_NOP = 3'h7;

  // Controller register map
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_CFG = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_RDLO = 8'h0C;
  localparam logic [7:0] OFS_RDHI = 8'h10;
  localparam int CMD_BA_LSB = 4;
  localparam int CMD_ADDR_LSB = 16;
  localparam int ST_OPEN_LSB = 8;
  localparam int ST_BEATS_LSB = 16;

  typedef enum logic [1:0] {CMD_NOP, CMD_ACT, CMD_PRE, CMD_READ} cmd_t;

  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [BA_W-1:0] ba;
    logic [ROW_W-1:0] addr;
  } cmd_pins_t;

  function automatic cmd_t decode(input cmd_pins_t p);
    cmd_t c;
    c = CMD_NOP;
    if (!p.cs_n) begin
      case ({p.ras_n, p.cas_n, p.we_n})
        PIN_ACT: c = CMD_ACT;
        PIN_PRE: c = CMD_PRE;
        PIN_READ: c = CMD_READ;
        default: c = CMD_NOP;
      endcase
    end
    return c;
  endfunction

  function automatic cmd_pins_t encode(input cmd_t c, input logic [BA_W-1:0] ba,
                                       input logic [ROW_W-1:0] addr);
    cmd_pins_t p;
    p.cs_n = 1'b0;
    p.ba = ba;
    p.addr = addr;
    unique case (c)
      CMD_ACT: {p.ras_n, p.cas_n, p.we_n} = PIN_ACT;
      CMD_PRE: {p.ras_n, p.cas_n, p.we_n} = PIN_PRE;
      CMD_READ: {p.ras_n, p.cas_n, p.we_n} = PIN_READ;
      CMD_NOP: {p.ras_n, p.cas_n, p.we_n} = PIN_NOP;
    endcase
    return p;
  endfunction

endpackage

/* dram_link_if.sv */
// Link between the DRAM device end and the controller end
`timescale 1ns/100ps
interface dram_link_if;
  import dram_pkg::*;

  logic ck;
  cmd_pins_t cmd;
  logic [DQ_W-1:0] dev_dq_o;
  logic dev_dq_oe;
  logic dev_dqs_o;
  logic dev_dqs_oe;
  logic [DQ_W-1:0] ctl_dq_o;
  logic ctl_dq_oe;
  logic ctl_dqs_o;
  logic ctl_dqs_oe;
  logic [DQ_W-1:0] dq;
  logic dqs;

  // Undriven bus reads as zero
  assign dq = dev_dq_oe ? dev_dq_o : (ctl_dq_oe ? ctl_dq_o : '0);
  assign dqs = dev_dqs_oe ? dev_dqs_o : (ctl_dqs_oe ? ctl_dqs_o : 1'b0);

  modport device (input ck, input cmd, input dq, input dqs,
                  output dev_dq_o, output dev_dq_oe, output dev_dqs_o, output dev_dqs_oe);
  modport controller (output ck, output cmd, input dq, input dqs,
                      output ctl_dq_o, output ctl_dq_oe, output ctl_dqs_o, output ctl_dqs_oe);
endinterface

/* dram_ctrl_end.sv */
// DRAM controller end: APB command registers, link clock and read capture
`timescale 1ns/100ps
module dram_ctrl_end
  import dram_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  dram_link_if.controller link,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  typedef struct packed {
    logic [2:0] div;
    logic ck;
    cmd_pins_t pins;
    logic pend;
    cmd_t op;
    logic [BA_W-1:0] ba;
    logic [ROW_W-1:0] addr;
    logic err;
    logic [3:0] al;
    logic [NBANK-1:0] open;
    logic [NBANK-1:0][CNT_W-1:0] rp;
    logic [NBANK-1:0][CNT_W-1:0] rc;
    logic [NBANK-1:0][CNT_W-1:0] ras;
    logic [NBANK-1:0][CNT_W-1:0] rtp;
    logic [CNT_W-1:0] ccd;
    logic [DQ_W-1:0] dq_s1;
    logic [DQ_W-1:0] dq_s2;
    logic [2:0] dqs_s;
    logic [7:0][DQ_W-1:0] rbuf;
    logic [3:0] nbeat;
    logic [31:0] prdata;
  } ctl_state_t;

  ctl_state_t q;
  ctl_state_t d;

  function automatic logic mapped(input logic [7:0] a);
    return a == OFS_CMD || a == OFS_CFG || a == OFS_STATUS || a == OFS_RDLO || a == OFS_RDHI;
  endfunction

  logic setup;
  logic access;
  logic pre_ok;

  assign setup = psel & ~penable;
  assign access = psel & penable;

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    d = q;
    pre_ok = 1'b1;
    d.dq_s1 = link.dq;
    d.dq_s2 = q.dq_s1;
    d.dqs_s = {q.dqs_s[1:0], link.dqs};

    // Capture a beat on each strobe edge, two per link clock
    if (q.dqs_s[1] != q.dqs_s[2] && q.nbeat != BEATS_BL8) begin
      d.rbuf[q.nbeat[2:0]] = q.dq_s2;
      d.nbeat = q.nbeat + 4'h1;
    end

    // Commands change on the falling link edge, device samples the rising
    if (q.div == PH_LAST) begin
      d.div = '0;
      d.ck = ~q.ck;
    end else begin
      d.div = q.div + 3'h1;
    end

    if (q.div == PH_LAST && q.ck) begin
      d.pins = encode(CMD_NOP, '0, '0);
      if (q.ccd != '0) d.ccd = q.ccd - 5'h01;
      for (int b = 0; b < NBANK; b++) begin
        if (q.rp[b] != '0) d.rp[b] = q.rp[b] - 5'h01;
        if (q.rc[b] != '0) d.rc[b] = q.rc[b] - 5'h01;
        if (q.ras[b] != '0) d.ras[b] = q.ras[b] - 5'h01;
        if (q.rtp[b] != '0) d.rtp[b] = q.rtp[b] - 5'h01;
        if ((q.addr[AP_BIT] || BA_W'(b) == q.ba) && (q.ras[b] != '0 || q.rtp[b] != '0)) begin
          pre_ok = 1'b0; // RQ16 RQ18
        end
      end
      if (q.pend) begin
        unique case (q.op)
          CMD_ACT: begin
            if (q.open[q.ba]) begin
              d.err = 1'b1; // RQ3
              d.pend = 1'b0;
            end else if (q.rp[q.ba] == '0 && q.rc[q.ba] == '0) begin // RQ5 RQ19
              d.pins = encode(CMD_ACT, q.ba, q.addr); // RQ1
              d.pend = 1'b0;
              d.open[q.ba] = 1'b1;
              d.ras[q.ba] = T_RAS_CK - 5'h01;
              d.rc[q.ba] = T_RC_CK - 5'h01;
            end
          end
          CMD_PRE: begin
            if (pre_ok) begin
              d.pins = encode(CMD_PRE, q.ba, q.addr); // RQ4
              d.pend = 1'b0;
              for (int b = 0; b < NBANK; b++) begin
                if (q.addr[AP_BIT] || BA_W'(b) == q.ba) begin
                  d.open[b] = 1'b0;
                  d.rp[b] = T_RP_CK - 5'h01; // RQ9
                end
              end
            end
          end
          CMD_READ: begin
            if (!q.open[q.ba]) begin
              d.err = 1'b1; // RQ7
              d.pend = 1'b0;
            end else if (q.ccd == '0) begin
              d.pins = encode(CMD_READ, q.ba, q.addr); // RQ10 RQ13
              d.pend = 1'b0;
              d.nbeat = '0;
              d.ccd = T_CCD_CK - 5'h01; // RQ11
              d.rtp[q.ba] = CNT_W'(q.al) + T_RTP_CK - 5'h01; // RQ16 RQ17
              if (q.addr[AP_BIT]) begin
                // Other banks stay usable while this one closes
                d.open[q.ba] = 1'b0; // RQ6
                d.rp[q.ba] = CNT_W'(q.al) + T_RTP_CK + T_RP_CK - 5'h01; // RQ6
              end
            end
          end
          CMD_NOP: d.pend = 1'b0;
        endcase
      end
    end

    // APB: read data registered in setup, writes land in access
    if (setup && !pwrite) begin
      unique case (paddr)
        OFS_CFG: d.prdata = {28'h0000000, q.al};
        OFS_STATUS: d.prdata = {12'h000, q.nbeat, q.open, 6'h00, q.err, q.pend};
        OFS_RDLO: d.prdata = q.rbuf[3:0];
        OFS_RDHI: d.prdata = q.rbuf[7:4];
        default: d.prdata = 32'h00000000;
      endcase
    end
    if (access && pwrite) begin
      if (paddr == OFS_CMD && !q.pend) begin
        d.op = cmd_t'(pwdata[1:0]);
        d.ba = pwdata[CMD_BA_LSB +: BA_W];
        d.addr = pwdata[CMD_ADDR_LSB +: ROW_W];
        d.pend = 1'b1;
        d.err = 1'b0;
      end else if (paddr == OFS_CFG) begin
        d.al = pwdata[3:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.pins.cs_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  assign prdata = q.prdata;
  assign pready = 1'b1;
  assign pslverr = access & ~mapped(paddr);
  assign link.ck = q.ck;
  assign link.cmd = q.pins;
  assign link.ctl_dq_o = '0;
  assign link.ctl_dq_oe = 1'b0;
  assign link.ctl_dqs_o = 1'b0;
  assign link.ctl_dqs_oe = 1'b0;

endmodule

/* dram_link_props.sv */
// Concurrent checks on the DRAM link between the device end and the controller end
`timescale 1ns/100ps
module dram_link_props
  import dram_pkg::*;
#(
  parameter int ADD_LAT = 1,
  parameter int RD_LAT = 3
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ck,
  input wire cmd_pins_t cmd,
  input wire logic [DQ_W-1:0] dq,
  input wire logic dqs,
  input wire logic dev_dq_oe
);
  ////////////////////////////////////////////////////////////////////////////////
  // Link clocks since each event, saturating so idle banks never look recent; oen_q counts pclk cycles of enable and wraps
  logic ck_q, rise, open_ev, close_ev, col_rd;
  logic [5:0] pre_q[NBANK];
  logic [5:0] opn_q[NBANK];
  logic [5:0] rdb_q[NBANK];
  logic [5:0] any_q, oen_q;
  logic [NBANK-1:0] live_q;
  logic [2:0] b;
  assign b = cmd.ba;
  assign rise = ck && !ck_q;
  assign open_ev = rise && !cmd.cs_n && {cmd.ras_n, cmd.cas_n, cmd.we_n} == PIN_ACT;
  assign close_ev = rise && !cmd.cs_n && {cmd.ras_n, cmd.cas_n, cmd.we_n} == PIN_PRE;
  assign col_rd = rise && !cmd.cs_n && {cmd.ras_n, cmd.cas_n, cmd.we_n} == PIN_READ;
  function automatic logic [5:0] inc(input logic [5:0] v);
    return (v == 6'h3F) ? v : v + 6'h01;
  endfunction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ck_q <= 1'b0;
      live_q <= '0;
      any_q <= 6'h3F;
      oen_q <= 6'h00;
      for (int i = 0; i < NBANK; i++) begin
        pre_q[i] <= 6'h3F;
        opn_q[i] <= 6'h3F;
        rdb_q[i] <= 6'h3F;
      end
    end else begin
      ck_q <= ck;
      oen_q <= dev_dq_oe ? oen_q + 6'h01 : 6'h00;
      any_q <= col_rd ? 6'h00 : (rise ? inc(any_q) : any_q);
      for (int i = 0; i < NBANK; i++) begin
        if (rise) begin
          pre_q[i] <= inc(pre_q[i]);
          opn_q[i] <= inc(opn_q[i]);
          rdb_q[i] <= inc(rdb_q[i]);
        end
        if (close_ev && (b == 3'(i) || cmd.addr[AP_BIT])) begin
          pre_q[i] <= 6'h00;
          live_q[i] <= 1'b0;
        end
      end
      if (open_ev) begin
        opn_q[b] <= 6'h00;
        live_q[b] <= 1'b1;
      end
      if (col_rd) begin
        rdb_q[b] <= 6'h00;
      end
      // Auto precharge timed from the read: a lower bound, so never a false alarm
      if (col_rd && cmd.addr[AP_BIT]) begin
        pre_q[b] <= 6'h00;
        live_q[b] <= 1'b0;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Counters read one less than the spacing at the edge of the second command
  property p_ccd; col_rd |-> any_q >= 6'(T_CCD_CK - 5'h01); endproperty
  a_ccd: assert property (p_ccd) else $error("read spacing short");
  property p_rp; open_ev |-> pre_q[b] >= 6'(T_RP_CK - 5'h01); endproperty
  a_rp: assert property (p_rp) else $error("activate inside precharge period");
  property p_rc; open_ev |-> opn_q[b] >= 6'(T_RC_CK - 5'h01); endproperty
  a_rc: assert property (p_rc) else $error("row cycle short");
  property p_ras; close_ev && !cmd.addr[AP_BIT] |-> opn_q[b] >= 6'(T_RAS_CK - 5'h01); endproperty
  a_ras: assert property (p_ras) else $error("precharge too soon after activate");
  property p_rtp;
    close_ev && !cmd.addr[AP_BIT] |-> int'(rdb_q[b]) >= ADD_LAT + int'(T_RTP_CK) - 1;
  endproperty
  a_rtp: assert property (p_rtp) else $error("precharge too soon after read");
  property p_idle; open_ev |-> !live_q[b]; endproperty
  a_idle: assert property (p_idle) else $error("activate over open row");
  property p_open; col_rd |-> live_q[b]; endproperty
  a_open: assert property (p_open) else $error("read to idle bank");
  property p_rl; $rose(dev_dq_oe) |-> any_q == 6'(RD_LAT); endproperty
  a_rl: assert property (p_rl) else $error("read latency off");
  property p_dqs; $rose(dev_dq_oe) |-> dqs ##4 !dqs ##4 dqs; endproperty
  a_dqs: assert property (p_dqs) else $error("strobe not toggling per beat");
  property p_step; dev_dq_oe && $fell(dqs) |-> dq == $past(dq) + 8'h01; endproperty
  a_step: assert property (p_step) else $error("beat value not stepping");
  property p_len; $fell(dev_dq_oe) |-> oen_q[3:0] == 4'h0; endproperty
  a_len: assert property (p_len) else $error("burst not 4 or 8 beats");
  c_chop: cover property (col_rd && !cmd.addr[BC_BIT]);
  c_auto: cover property (col_rd && cmd.addr[AP_BIT]);
  c_all: cover property (close_ev && cmd.addr[AP_BIT]);
endmodule

/* dram_bank_row_read_control_tb_top.sv */
// Testbench joining the DRAM device end and controller end over the link
`timescale 1ns/100ps
module dram_bank_row_read_control_tb_top;
  import dram_pkg::*;
  localparam int ADD_LAT = 1;
  localparam int CAS_LAT = 2;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, perr, protocol_error, read_busy;
  logic oe_q, dqs_q;
  logic [7:0] paddr, last;
  logic [31:0] pwdata, prdata, st;
  logic [1:0] burst_mode;
  logic [NBANK-1:0] bank_open;
  logic [11:0] exp_q[$];
  logic [11:0] cur;
  logic [15:0] row[NBANK];
  int err_count, comparisons, beat, last_n, b;
  dram_link_if link();
  dram_device_end dram_device_end_i (
    .pclk(pclk), .presetn(presetn), .link(link), .burst_mode(burst_mode),
    .additive_latency(4'(ADD_LAT)), .cas_latency(4'(CAS_LAT)),
    .bank_open(bank_open), .protocol_error(protocol_error), .read_busy(read_busy));
  dram_ctrl_end dram_ctrl_end_i (
    .pclk(pclk), .presetn(presetn), .link(link), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  dram_link_props #(.ADD_LAT(ADD_LAT), .RD_LAT(ADD_LAT + CAS_LAT)) dram_link_props_i (
    .pclk(pclk), .presetn(presetn), .ck(link.ck), .cmd(link.cmd), .dq(link.dq),
    .dqs(link.dqs), .dev_dq_oe(link.dev_dq_oe));
  always #20 pclk = ~pclk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic stop_test;
    if (err_count == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic tmo(input bit hit);
    if (hit) begin
      chk("timeout", 32'h0, 32'h1);
      stop_test;
    end
  endtask
  // Leading edge wait keeps back-to-back calls from assigning psel twice in one step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    st = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    tmo(n >= 50);
  endtask
  task automatic cmd(input logic [1:0] op, input int bk, input logic [15:0] a);
    int n;
    apb(1'b1, OFS_CMD, {a, 9'h000, 3'(bk), 2'h0, op});
    n = 0;
    do begin
      apb(1'b0, OFS_STATUS, 32'h0);
      n++;
    end while (st[0] !== 1'b0 && n < 200);
    tmo(n >= 200);
  endtask
  task automatic rd(input int bk, input logic bc, input logic ap);
    logic [7:0] col;
    col = 8'($urandom);
    last_n = (burst_mode == BURST_FIX4 || (burst_mode == BURST_OTF && !bc)) ? 4 : 8;
    last = row[bk][7:0] ^ col;
    exp_q.push_back({4'(last_n), last});
    cmd(2'(CMD_READ), bk, {3'h0, bc, 1'b0, ap, 2'h0, col});
  endtask
  task automatic wait_open(input logic [7:0] exp);
    int n;
    n = 0;
    while (bank_open !== exp && n < 80) begin
      @(posedge pclk);
      n++;
    end
    chk("bank_open", 32'(exp), 32'(bank_open));
    tmo(n >= 80);
  endtask
  task automatic drain;
    int n;
    n = 0;
    while ((exp_q.size() != 0 || beat != 0 || read_busy !== 1'b0) && n < 600) begin
      @(posedge pclk);
      n++;
    end
    tmo(n >= 600);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Burst monitor: a beat starts at the enable rise or at any strobe change
  always @(posedge pclk) begin
    if (link.dev_dq_oe === 1'b1 && (oe_q !== 1'b1 || link.dqs !== dqs_q)) begin
      if (beat == 0) begin
        cur = (exp_q.size() != 0) ? exp_q.pop_front() : 12'h000;
        chk("burst expected", 32'h1, 32'(cur != 12'h000));
      end
      chk("read beat", 32'(8'(cur[7:0] + 8'(beat))), 32'(link.dq));
      beat++;
      if (beat >= int'(cur[11:8])) beat = 0;
    end
    if (protocol_error !== 1'b0) chk("protocol_error", 32'h0, 32'h1);
    oe_q <= link.dev_dq_oe;
    dqs_q <= link.dqs;
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    burst_mode = BURST_FIX8;
    err_count = 0;
    comparisons = 0;
    void'($urandom(32'h1C937FC9));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("status", 32'h0, st);
    apb(1'b0, 8'hFC, 32'h0);
    chk("unmapped err", 32'h1, 32'(perr));
    chk("unmapped data", 32'h0, st);
    apb(1'b1, OFS_CFG, 32'(ADD_LAT));
    for (int m = 0; m < 4; m++) begin
      burst_mode <= 2'(m);
      b = $urandom_range(7, 0);
      row[b] = 16'($urandom);
      cmd(2'(CMD_ACT), b, row[b]);
      wait_open(8'(1 << b));
      rd(b, 1'b0, 1'b0);
      rd(b, 1'b1, 1'b0);
      // Capture restarts at issue, so the checked read must not overlap a burst
      drain;
      rd(b, 1'b1, 1'b1);
      drain;
      wait_open(8'h00);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk("beats", 32'(last_n), 32'(st[19:16]));
      apb(1'b0, OFS_RDLO, 32'h0);
      chk("rdlo", {last + 8'h03, last + 8'h02, last + 8'h01, last}, st);
      apb(1'b0, OFS_RDHI, 32'h0);
      if (last_n == 8) chk("rdhi", {last + 8'h07, last + 8'h06, last + 8'h05, last + 8'h04}, st);
    end
    burst_mode <= BURST_OTF;
    row[0] = 16'($urandom);
    row[5] = 16'($urandom);
    cmd(2'(CMD_ACT), 0, row[0]);
    cmd(2'(CMD_ACT), 5, row[5]);
    wait_open(8'h21);
    cmd(2'(CMD_ACT), 0, 16'h0001);
    chk("refused", 32'h1, 32'(st[1]));
    chk("ctl open", 32'h21, 32'(st[15:8]));
    rd(5, 1'b1, 1'b1);
    rd(0, 1'b0, 1'b0);
    drain;
    wait_open(8'h01);
    cmd(2'(CMD_PRE), 0, 16'h0000);
    wait_open(8'h00);
    cmd(2'(CMD_PRE), 0, 16'h0000);
    chk("refused", 32'h0, 32'(st[1]));
    cmd(2'(CMD_READ), 0, 16'h0000);
    chk("refused", 32'h1, 32'(st[1]));
    cmd(2'(CMD_ACT), 2, 16'($urandom));
    cmd(2'(CMD_ACT), 3, 16'($urandom));
    wait_open(8'h0C);
    cmd(2'(CMD_PRE), 1, 16'h0400);
    wait_open(8'h00);
    cmd(2'(CMD_ACT), 3, 16'($urandom));
    wait_open(8'h08);
    chk("pending", 32'h0, 32'(exp_q.size()));
    stop_test;
  end
endmodule
